// ==== ptb_cfg.svh ====
`ifndef PTB_CFG_SVH
`define PTB_CFG_SVH

// ========
// Widths and bus shape
// ========
`define PTB_BACKEND_ADDR_WIDTH_PARAM 24
`define PTB_DATA_WIDTH 64
`define PTB_WIDE_BUS 1'b1
`define PTB_CNT_W 5

// ========
// Configuration header offsets, reset values, fixed bits
// ========
`define PTB_CFG_PRIMARY_MEMORY_BASE_OFS 8'h10
`define PTB_CFG_SECONDARY_SPACE_BASE_OFS 8'h14
`define PTB_PRIMARY_MEMORY_BASE_RST 32'h00000000
`define PTB_SECONDARY_SPACE_BASE_RST 32'h00000001
`define PTB_PRIMARY_MEMORY_BASE_RO_MASK 32'h00FFFFFF
`define PTB_SECONDARY_SPACE_BASE_RO_MASK 32'h000000FF
`define PTB_PRIMARY_MEMORY_BASE_CMP_LSB 24
`define PTB_SECONDARY_SPACE_BASE_CMP_LSB 8
`define PTB_CFG_OFS_MSB 7

// ========
// Bus commands
// ========
`define PTB_CMD_IO_RD 4'h2
`define PTB_CMD_IO_WR 4'h3
`define PTB_CMD_MEM_RD 4'h6
`define PTB_CMD_MEM_WR 4'h7
`define PTB_CMD_CFG_RD 4'hA
`define PTB_CMD_CFG_WR 4'hB

// ========
// Timing (PCI target latency limit, in clocks) and address steps (in bytes)
// ========
`define PTB_RDY_TIMEOUT 5'h10
`define PTB_STEP_32 8'h04
`define PTB_STEP_64 8'h08

`endif

// ==== ptb_pkg.sv ====
package ptb_pkg;
`include "ptb_cfg.svh"

    // ========
    // Controller states
    // ========
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_TERM = 3'b100
    } ptb_state_t;

    // ========
    // Controller state, except the pipeline and timeout counters
    // ========
    typedef struct packed {
        logic [`PTB_DATA_WIDTH-1:0] ad_s1;
        logic [`PTB_DATA_WIDTH-1:0] ad_s2;
        logic [7:0] cbe_n_s1;
        logic [7:0] cbe_n_s2;
        logic frame_n_s1;
        logic frame_n_s2;
        logic irdy_n_s1;
        logic irdy_n_s2;
        logic req64_n_s1;
        logic req64_n_s2;
        logic idsel_s1;
        logic idsel_s2;
        ptb_state_t state;
        logic [31:0] primary_memory_base;
        logic [31:0] secondary_space_base;
        logic started;
        logic rd_take;
        logic wide;
        logic mem_hit;
        logic sec_hit;
        logic cfg_hit;
        logic rd;
        logic wr;
        logic start;
        logic start64;
        logic done;
        logic rd_lo;
        logic rd_hi;
        logic [3:0] wr_lo;
        logic [3:0] wr_hi;
        logic [`PTB_BACKEND_ADDR_WIDTH_PARAM-1:0] addr;
        logic [`PTB_DATA_WIDTH-1:0] mem_do;
        logic mem_oe;
        logic [`PTB_DATA_WIDTH-1:0] ad_o;
        logic ad_oe;
        logic trdy_n;
        logic stop_n;
        logic devsel_n;
        logic ack64_n;
        logic gnt;
    } ptb_regs_t;

endpackage

// ==== ptb_down_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_cfg.svh"

module ptb_down_counter (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [`PTB_CNT_W-1:0] i_load_val,
    input wire logic i_dec,
    output logic o_zero
);
    logic [`PTB_CNT_W-1:0] count_q;
    logic [`PTB_CNT_W-1:0] count_d;

    // ======================================================
    // Load wins over count; saturates at zero
    // ======================================================
    always_comb begin
        count_d = count_q;
        if (i_load) begin
            count_d = i_load_val;
        end else if (i_dec && (count_q != '0)) begin
            count_d = count_q - `PTB_CNT_W'(1);
        end
    end

    // Register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign o_zero = (count_q == '0);
endmodule
`default_nettype wire

// ==== ptb_target_backend.sv ====
// Contract
// - flag primary memory hits decoded against base register at offset 10H
// - flag secondary space hits decoded against base register at 14H
// - flag configuration space accesses toward the back-end
// - drive separate read and write direction flags
// - data moves on a shared 64-bit (or 32-bit) two-way bus
// - memory address bus is address-width parameter bits wide
// - one start pulse per transaction; wide start pulse with it for 64-bit
// - one done pulse when a transaction to the back-end ends
// - read strobes only when back-end read ready and master ready
// - low read strobe covers low 32 bits, wide one upper 32
// - read ready too late gives a disconnect without data
// - write strobes only with valid data, write ready and master ready
// - low write strobes are byte enables, bit 0 for byte 0
// - wide write strobes are byte enables, bit 0 for byte 4
// - cycle flags valid with start pulse, held until done pulse
// - non-zero pipeline count advances address, first strobes carry no data
// - back-end error input ends the transfer with a target abort
// - while the back-end holds the grant, new transactions get retry
`timescale 1ns/100ps
`default_nettype none
`include "ptb_cfg.svh"

module ptb_target_backend (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic [`PTB_DATA_WIDTH-1:0] I_AD_I,
    output logic [`PTB_DATA_WIDTH-1:0] O_AD_O,
    output logic O_AD_OE,
    input wire logic [7:0] I_CBE_N,
    input wire logic I_FRAME_N,
    input wire logic I_IRDY_N,
    input wire logic I_REQ64_N,
    input wire logic I_IDSEL,
    output logic O_TRDY_N,
    output logic O_STOP_N,
    output logic O_DEVSEL_N,
    output logic O_ACK64_N,
    output logic O_PRIMARY_MEM_HIT_FLAG,
    output logic O_SECONDARY_SPACE_HIT_FLAG,
    output logic O_CFG_ACCESS_FLAG,
    output logic O_RD_DIRECTION_FLAG,
    output logic O_WR_DIRECTION_FLAG,
    output logic [`PTB_BACKEND_ADDR_WIDTH_PARAM-1:0] O_MEM_ADDR,
    input wire logic [`PTB_DATA_WIDTH-1:0] I_MEM_DATA_I,
    output logic [`PTB_DATA_WIDTH-1:0] O_MEM_DATA_O,
    output logic O_MEM_DATA_OE,
    output logic O_XFER_BEGIN_PULSE,
    output logic O_WIDE_XFER_BEGIN_PULSE,
    output logic O_XFER_END_PULSE,
    output logic O_LOW_RD_STROBE,
    output logic O_HIGH_RD_STROBE,
    input wire logic I_BACKEND_RD_READY,
    output logic [3:0] O_LOW_WR_BYTE_STROBES,
    output logic [3:0] O_HIGH_WR_BYTE_STROBES,
    input wire logic I_BACKEND_WR_READY,
    input wire logic [2:0] I_PIPELINE_LATENCY_COUNT,
    input wire logic I_BACKEND_OWNERSHIP_REQUEST,
    output logic O_BACKEND_OWNERSHIP_GRANT,
    input wire logic I_BACKEND_ERROR
);
    import ptb_pkg::*;

    // ========
    // Helpers
    // ========
    // Byte-lane merge of a config write; fixed bits keep old value
    function automatic logic [31:0] cfg_merge(input logic [31:0] old,
        input logic [31:0] wdata, input logic [3:0] be_n,
        input logic [31:0] ro_mask);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (!be_n[i]) begin
                m[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return (m & ~ro_mask) | (old & ro_mask);
    endfunction

    // Read-type command decode, used for all three spaces
    function automatic logic cmd_is_read(input logic [3:0] cmd);
        return (cmd == `PTB_CMD_IO_RD) || (cmd == `PTB_CMD_MEM_RD) ||
            (cmd == `PTB_CMD_CFG_RD);
    endfunction

    ptb_regs_t r;
    ptb_regs_t n;
    logic pipe_load;
    logic pipe_dec;
    logic pipe_zero;
    logic tmo_load;
    logic tmo_dec;
    logic tmo_zero;

    // ========
    // Counters: pipeline skip and ready timeout
    // ========
    ptb_down_counter u_pipe (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_load(pipe_load),
        .i_load_val({2'h0, I_PIPELINE_LATENCY_COUNT}),
        .i_dec(pipe_dec),
        .o_zero(pipe_zero)
    );

    ptb_down_counter u_tmo (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_load(tmo_load),
        .i_load_val(`PTB_RDY_TIMEOUT),
        .i_dec(tmo_dec),
        .o_zero(tmo_zero)
    );

    // ========
    // Next-state logic
    // ========
    always_comb begin
        logic frame_act;
        logic irdy_act;
        logic [3:0] cmd;
        logic [31:0] ad32;
        logic is_mem;
        logic is_io;
        logic is_cfg;
        logic issue;
        logic finish;
        n = r;
        frame_act = !r.frame_n_s2;
        irdy_act = !r.irdy_n_s2;
        cmd = r.cbe_n_s2[3:0];
        ad32 = r.ad_s2[31:0];
        is_mem = 1'b0;
        is_io = 1'b0;
        is_cfg = 1'b0;
        issue = 1'b0;
        finish = 1'b0;
        pipe_load = 1'b0;
        pipe_dec = 1'b0;
        tmo_load = 1'b0;
        tmo_dec = 1'b0;
        // Pin inputs pass two flops before use
        n.ad_s1 = I_AD_I;
        n.ad_s2 = r.ad_s1;
        n.cbe_n_s1 = I_CBE_N;
        n.cbe_n_s2 = r.cbe_n_s1;
        n.frame_n_s1 = I_FRAME_N;
        n.frame_n_s2 = r.frame_n_s1;
        n.irdy_n_s1 = I_IRDY_N;
        n.irdy_n_s2 = r.irdy_n_s1;
        n.req64_n_s1 = I_REQ64_N;
        n.req64_n_s2 = r.req64_n_s1;
        n.idsel_s1 = I_IDSEL;
        n.idsel_s2 = r.idsel_s1;
        // Pulses default low
        n.start = 1'b0;
        n.start64 = 1'b0;
        n.done = 1'b0;
        n.rd_lo = 1'b0;
        n.rd_hi = 1'b0;
        n.wr_lo = '0;
        n.wr_hi = '0;
        n.rd_take = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                // Grant only changes between transactions
                if (!frame_act) begin
                    n.gnt = I_BACKEND_OWNERSHIP_REQUEST;
                end
                if (frame_act) begin
                    is_mem = ((cmd == `PTB_CMD_MEM_RD) ||
                        (cmd == `PTB_CMD_MEM_WR)) &&
                        (ad32[31:`PTB_PRIMARY_MEMORY_BASE_CMP_LSB] ==
                        r.primary_memory_base[31:`PTB_PRIMARY_MEMORY_BASE_CMP_LSB]);
                    is_io = ((cmd == `PTB_CMD_IO_RD) ||
                        (cmd == `PTB_CMD_IO_WR)) &&
                        (ad32[31:`PTB_SECONDARY_SPACE_BASE_CMP_LSB] ==
                        r.secondary_space_base[31:`PTB_SECONDARY_SPACE_BASE_CMP_LSB]);
                    is_cfg = ((cmd == `PTB_CMD_CFG_RD) ||
                        (cmd == `PTB_CMD_CFG_WR)) && r.idsel_s2 &&
                        (ad32[1:0] == 2'h0);
                    n.state = ST_TERM;
                    if (is_mem || is_io || is_cfg) begin
                        n.devsel_n = 1'b0;
                        if (r.gnt) begin
                            n.stop_n = 1'b0;
                        end else begin
                            n.state = ST_XFER;
                            n.started = 1'b1;
                            n.wide = `PTB_WIDE_BUS && !r.req64_n_s2;
                            n.ack64_n = !n.wide;
                            n.start = 1'b1;
                            n.start64 = n.wide;
                            // Flags set with start, held to done
                            n.mem_hit = is_mem;
                            n.sec_hit = is_io;
                            n.cfg_hit = is_cfg;
                            n.rd = cmd_is_read(cmd);
                            n.wr = !cmd_is_read(cmd);
                            n.addr = ad32[`PTB_BACKEND_ADDR_WIDTH_PARAM-1:0];
                            n.ad_oe = cmd_is_read(cmd);
                            n.mem_oe = !cmd_is_read(cmd) && !is_cfg;
                            pipe_load = 1'b1;
                            tmo_load = 1'b1;
                        end
                    end
                end
            end
            ST_XFER: begin
                n.trdy_n = 1'b1;
                n.mem_do = r.ad_s2;
                if (r.cfg_hit) begin
                    // Single data phase, then disconnect
                    if (irdy_act && r.trdy_n && r.stop_n) begin
                        n.trdy_n = 1'b0;
                        n.stop_n = 1'b0;
                        n.ad_o = '0;
                        if (r.addr[`PTB_CFG_OFS_MSB:0] == `PTB_CFG_PRIMARY_MEMORY_BASE_OFS) begin
                            n.ad_o[31:0] = r.primary_memory_base;
                            if (r.wr) begin
                                n.primary_memory_base = cfg_merge(r.primary_memory_base, ad32,
                                    r.cbe_n_s2[3:0], `PTB_PRIMARY_MEMORY_BASE_RO_MASK);
                            end
                        end
                        if (r.addr[`PTB_CFG_OFS_MSB:0] == `PTB_CFG_SECONDARY_SPACE_BASE_OFS) begin
                            n.ad_o[31:0] = r.secondary_space_base;
                            if (r.wr) begin
                                n.secondary_space_base = cfg_merge(r.secondary_space_base, ad32,
                                    r.cbe_n_s2[3:0], `PTB_SECONDARY_SPACE_BASE_RO_MASK);
                            end
                        end
                    end
                end else begin
                    // One strobe per data phase after the fill strobes, while no answer pending
                    issue = irdy_act && r.trdy_n && !r.rd_take &&
                        (r.rd ? I_BACKEND_RD_READY : I_BACKEND_WR_READY);
                    if (issue && r.rd) begin
                        n.rd_lo = 1'b1;
                        n.rd_hi = r.wide;
                    end
                    if (issue && r.wr) begin
                        n.wr_lo = ~r.cbe_n_s2[3:0];
                        n.wr_hi = r.wide ? ~r.cbe_n_s2[7:4] : 4'h0;
                    end
                    // Step after each strobe so address stands with data
                    if (r.rd_lo || (|{r.wr_hi, r.wr_lo})) begin
                        n.addr = r.addr + `PTB_BACKEND_ADDR_WIDTH_PARAM'(r.wide ?
                            `PTB_STEP_64 : `PTB_STEP_32);
                    end
                    if (issue) begin
                        pipe_dec = !pipe_zero;
                        if (pipe_zero) begin
                            tmo_load = 1'b1;
                            if (r.rd) begin
                                n.rd_take = 1'b1;
                            end else begin
                                n.trdy_n = 1'b0;
                            end
                        end
                    end else begin
                        tmo_dec = 1'b1;
                    end
                    // Read data taken the edge after the strobe
                    if (r.rd_take) begin
                        n.ad_o = I_MEM_DATA_I;
                        n.trdy_n = 1'b0;
                    end
                    // Last phase done; stale synced IRDY must not re-issue
                    if (!r.trdy_n && !frame_act) begin
                        n.state = ST_TERM;
                    end
                    // Back-end too slow: disconnect, no data moves
                    if (tmo_zero && !issue && !r.rd_take) begin
                        n.stop_n = 1'b0;
                        n.state = ST_TERM;
                    end
                    if (I_BACKEND_ERROR) begin
                        n.stop_n = 1'b0;
                        n.devsel_n = 1'b1;
                        n.trdy_n = 1'b1;
                        n.state = ST_TERM;
                    end
                end
                finish = !frame_act && !irdy_act;
            end
            ST_TERM: begin
                n.trdy_n = 1'b1;
                finish = !frame_act && !irdy_act;
            end
        endcase
        // Close out: done pulse only for transactions that started
        if (finish) begin
            n.state = ST_IDLE;
            n.done = r.started;
            n.started = 1'b0;
            n.mem_hit = 1'b0;
            n.sec_hit = 1'b0;
            n.cfg_hit = 1'b0;
            n.rd = 1'b0;
            n.wr = 1'b0;
            n.trdy_n = 1'b1;
            n.stop_n = 1'b1;
            n.devsel_n = 1'b1;
            n.ack64_n = 1'b1;
            n.ad_oe = 1'b0;
            n.mem_oe = 1'b0;
        end
    end

    // ========
    // State register; active-low lines idle high
    // ========
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.cbe_n_s1 <= 8'hFF;
            r.cbe_n_s2 <= 8'hFF;
            r.frame_n_s1 <= 1'b1;
            r.frame_n_s2 <= 1'b1;
            r.irdy_n_s1 <= 1'b1;
            r.irdy_n_s2 <= 1'b1;
            r.req64_n_s1 <= 1'b1;
            r.req64_n_s2 <= 1'b1;
            r.primary_memory_base <= `PTB_PRIMARY_MEMORY_BASE_RST;
            r.secondary_space_base <= `PTB_SECONDARY_SPACE_BASE_RST;
            r.trdy_n <= 1'b1;
            r.stop_n <= 1'b1;
            r.devsel_n <= 1'b1;
            r.ack64_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ========
    // Outputs, all straight from the state register
    // ========
    assign O_AD_O = r.ad_o;
    assign O_AD_OE = r.ad_oe;
    assign O_TRDY_N = r.trdy_n;
    assign O_STOP_N = r.stop_n;
    assign O_DEVSEL_N = r.devsel_n;
    assign O_ACK64_N = r.ack64_n;
    assign O_PRIMARY_MEM_HIT_FLAG = r.mem_hit;
    assign O_SECONDARY_SPACE_HIT_FLAG = r.sec_hit;
    assign O_CFG_ACCESS_FLAG = r.cfg_hit;
    assign O_RD_DIRECTION_FLAG = r.rd;
    assign O_WR_DIRECTION_FLAG = r.wr;
    assign O_MEM_ADDR = r.addr;
    assign O_MEM_DATA_O = r.mem_do;
    assign O_MEM_DATA_OE = r.mem_oe;
    assign O_XFER_BEGIN_PULSE = r.start;
    assign O_WIDE_XFER_BEGIN_PULSE = r.start64;
    assign O_XFER_END_PULSE = r.done;
    assign O_LOW_RD_STROBE = r.rd_lo;
    assign O_HIGH_RD_STROBE = r.rd_hi;
    assign O_LOW_WR_BYTE_STROBES = r.wr_lo;
    assign O_HIGH_WR_BYTE_STROBES = r.wr_hi;
    assign O_BACKEND_OWNERSHIP_GRANT = r.gnt;
endmodule
`default_nettype wire

// ==== ptb_target_backend_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none

module ptb_target_backend_monitor (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_BACKEND_RD_READY,
    input wire logic I_BACKEND_WR_READY,
    input wire logic O_ACK64_N,
    input wire logic O_DEVSEL_N,
    input wire logic O_CFG_ACCESS_FLAG,
    input wire logic O_RD_DIRECTION_FLAG,
    input wire logic O_WR_DIRECTION_FLAG,
    input wire logic O_MEM_DATA_OE,
    input wire logic O_XFER_BEGIN_PULSE,
    input wire logic O_WIDE_XFER_BEGIN_PULSE,
    input wire logic O_XFER_END_PULSE,
    input wire logic O_LOW_RD_STROBE,
    input wire logic O_HIGH_RD_STROBE,
    input wire logic [3:0] O_LOW_WR_BYTE_STROBES,
    input wire logic O_BACKEND_OWNERSHIP_GRANT
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    // ========
    // Framing pulses and cycle flags
    // ========
    a_begin_one_cycle: assert property (
        O_XFER_BEGIN_PULSE |=> !O_XFER_BEGIN_PULSE)
        else $error("long begin");
    a_wide_with_begin: assert property (
        O_WIDE_XFER_BEGIN_PULSE |-> O_XFER_BEGIN_PULSE && !O_ACK64_N)
        else $error("bad wide begin");
    a_begin_claimed: assert property (
        O_XFER_BEGIN_PULSE |-> !O_DEVSEL_N)
        else $error("begin unclaimed");
    a_flags_at_begin: assert property (
        $rose(O_RD_DIRECTION_FLAG) || $rose(O_WR_DIRECTION_FLAG)
        |-> O_XFER_BEGIN_PULSE)
        else $error("flag rose late");
    a_flags_held: assert property (
        O_RD_DIRECTION_FLAG && !O_XFER_END_PULSE
        |=> O_RD_DIRECTION_FLAG || O_XFER_END_PULSE)
        else $error("flag dropped early");
    a_one_direction: assert property (
        O_XFER_BEGIN_PULSE |-> O_RD_DIRECTION_FLAG ^ O_WR_DIRECTION_FLAG)
        else $error("bad direction");

    // ========
    // Back-end strobes and ownership grant
    // ========
    a_rd_strobe_ready: assert property (
        O_LOW_RD_STROBE |-> $past(I_BACKEND_RD_READY) && O_RD_DIRECTION_FLAG)
        else $error("bad read strobe");
    a_wr_strobe_ready: assert property (
        |O_LOW_WR_BYTE_STROBES
        |-> $past(I_BACKEND_WR_READY) && O_WR_DIRECTION_FLAG && O_MEM_DATA_OE)
        else $error("bad write strobe");
    a_hi_rd_wide: assert property (
        O_HIGH_RD_STROBE |-> !O_ACK64_N)
        else $error("narrow upper read");
    a_cfg_no_strobe: assert property (
        O_CFG_ACCESS_FLAG |-> !O_LOW_RD_STROBE && O_LOW_WR_BYTE_STROBES == 4'h0)
        else $error("strobe in config");
    a_grant_no_begin: assert property (
        O_BACKEND_OWNERSHIP_GRANT |-> !O_XFER_BEGIN_PULSE)
        else $error("begin while granted");

    // Main scenarios reached
    c_wide: cover property (O_WIDE_XFER_BEGIN_PULSE);
    c_read: cover property (O_LOW_RD_STROBE);
    c_retry: cover property (O_BACKEND_OWNERSHIP_GRANT && !O_DEVSEL_N);
endmodule

bind ptb_target_backend ptb_target_backend_monitor u_mon (
    .I_CORE_CLK, .I_RST, .I_BACKEND_RD_READY, .I_BACKEND_WR_READY,
    .O_ACK64_N, .O_DEVSEL_N, .O_CFG_ACCESS_FLAG, .O_RD_DIRECTION_FLAG,
    .O_WR_DIRECTION_FLAG, .O_MEM_DATA_OE, .O_XFER_BEGIN_PULSE,
    .O_WIDE_XFER_BEGIN_PULSE, .O_XFER_END_PULSE, .O_LOW_RD_STROBE,
    .O_HIGH_RD_STROBE, .O_LOW_WR_BYTE_STROBES, .O_BACKEND_OWNERSHIP_GRANT
);
`default_nettype wire

// ==== ptb_backend_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_cfg.svh"

module ptb_backend_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    input wire logic [2:0] i_skip,
    input wire logic i_begin,
    input wire logic [`PTB_BACKEND_ADDR_WIDTH_PARAM-1:0] i_addr,
    input wire logic i_rd_lo,
    input wire logic [7:0] i_wr_be,
    input wire logic [`PTB_DATA_WIDTH-1:0] i_wdata,
    output logic o_rd_ready,
    output logic o_wr_ready,
    output logic [`PTB_DATA_WIDTH-1:0] o_rdata,
    output logic [7:0] o_be,
    output logic [`PTB_DATA_WIDTH-1:0] o_wdata,
    output logic [`PTB_BACKEND_ADDR_WIDTH_PARAM-1:0] o_waddr,
    output logic [7:0] o_strobes
);
    logic [2:0] skip_q;
    logic [`PTB_DATA_WIDTH-1:0] pat;

    // ========
    // Ready levels and read data
    // ========
    assign o_rd_ready = !i_stall;
    assign o_wr_ready = !i_stall;
    assign pat = {8'hC3, i_addr, 8'h3C, i_addr};
    // Inverted pattern off-strobe so stale data never looks valid
    assign o_rdata = i_rd_lo ? pat : ~pat;

    // Log writes past the fill strobes
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            skip_q <= 3'h0;
            o_strobes <= 8'h00;
            o_be <= 8'h00;
        end else if (i_begin) begin
            skip_q <= i_skip;
        end else if (i_rd_lo || |i_wr_be) begin
            o_strobes <= o_strobes + 8'h01;
            if (skip_q != 3'h0) begin
                skip_q <= skip_q - 3'h1;
            end else if (|i_wr_be) begin
                o_be <= i_wr_be;
                o_wdata <= i_wdata;
                o_waddr <= i_addr;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ptb_target_backend_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module ptb_target_backend_tb_top;
    logic clk, rst, frame_n, irdy_n, req64_n, idsel, stall, err, breq;
    logic trdy, stop, dev, trdy_n, stop_n, devsel_n, rdy_r, rdy_w, grant;
    logic f_pri, f_sec, f_cfg, f_rd, f_wr, beg, beg64, fin, rd_lo;
    logic [63:0] ad, rdv, ad_o, md_i, md_o, b_wd;
    logic [7:0] cbe_n, b_be, b_n;
    logic [3:0] wr_lo, wr_hi;
    logic [2:0] lat;
    logic [5:0] fl;
    logic [23:0] maddr, b_wa;
    int n_fail = 0, n_tests = 0, n_end = 0, cyc = 0;

    ptb_target_backend DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_AD_I(ad),
        .O_AD_O(ad_o), .O_AD_OE(), .I_CBE_N(cbe_n), .I_FRAME_N(frame_n),
        .I_IRDY_N(irdy_n), .I_REQ64_N(req64_n), .I_IDSEL(idsel),
        .O_TRDY_N(trdy_n), .O_STOP_N(stop_n), .O_DEVSEL_N(devsel_n),
        .O_ACK64_N(), .O_PRIMARY_MEM_HIT_FLAG(f_pri),
        .O_SECONDARY_SPACE_HIT_FLAG(f_sec), .O_CFG_ACCESS_FLAG(f_cfg),
        .O_RD_DIRECTION_FLAG(f_rd), .O_WR_DIRECTION_FLAG(f_wr),
        .O_MEM_ADDR(maddr), .I_MEM_DATA_I(md_i), .O_MEM_DATA_O(md_o),
        .O_MEM_DATA_OE(), .O_XFER_BEGIN_PULSE(beg),
        .O_WIDE_XFER_BEGIN_PULSE(beg64), .O_XFER_END_PULSE(fin),
        .O_LOW_RD_STROBE(rd_lo), .O_HIGH_RD_STROBE(),
        .I_BACKEND_RD_READY(rdy_r), .O_LOW_WR_BYTE_STROBES(wr_lo),
        .O_HIGH_WR_BYTE_STROBES(wr_hi), .I_BACKEND_WR_READY(rdy_w),
        .I_PIPELINE_LATENCY_COUNT(lat), .I_BACKEND_OWNERSHIP_REQUEST(breq),
        .O_BACKEND_OWNERSHIP_GRANT(grant), .I_BACKEND_ERROR(err));

    ptb_backend_model u_be (.i_clk(clk), .i_rst(rst), .i_stall(stall),
        .i_skip(lat), .i_begin(beg), .i_addr(maddr), .i_rd_lo(rd_lo),
        .i_wr_be({wr_hi, wr_lo}), .i_wdata(md_o), .o_rd_ready(rdy_r),
        .o_wr_ready(rdy_w), .o_rdata(md_i), .o_be(b_be), .o_wdata(b_wd),
        .o_waddr(b_wa), .o_strobes(b_n));

    // ========
    // Clock, flag capture at begin, hang guard
    // ========
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (beg) fl <= {beg64, f_pri, f_sec, f_cfg, f_rd, f_wr};
        if (fin) n_end <= n_end + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            results();
        end
    end

    task automatic results();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Single data phase; IRDY held through the clock edge after the answer edge
    task automatic pci(input logic [3:0] cmd, input logic [31:0] adr,
            input logic [63:0] wd, input logic [7:0] be, input logic w64);
        fl = 6'h00;
        frame_n = 1'b0;
        ad = {32'h0, adr};
        cbe_n = {4'hF, cmd};
        req64_n = !w64;
        idsel = (cmd[3:1] == 3'b101);
        @(posedge clk) #1;
        frame_n = 1'b1;
        req64_n = 1'b1;
        idsel = 1'b0;
        irdy_n = 1'b0;
        ad = wd;
        cbe_n = ~be;
        trdy = 1'b0;
        stop = 1'b0;
        for (int k = 0; k < 40 && !trdy && !stop; k++) begin
            @(posedge clk) #1;
            trdy = !trdy_n;
            stop = !stop_n;
            dev = devsel_n;
            rdv = ad_o;
        end
        @(posedge clk) #1;
        irdy_n = 1'b1;
        ad = ~wd;
        cbe_n = 8'hFF;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // ========
    // Scenarios
    // ========
    task automatic t_cfg();
        pci(`PTB_CMD_CFG_RD, 32'h10, 64'h0, 8'h0F, 1'b0);
        `CHK(rdv[31:0], `PTB_PRIMARY_MEMORY_BASE_RST)
        `CHK(fl[2:0], 3'b110)
        pci(`PTB_CMD_CFG_RD, 32'h14, 64'h0, 8'h0F, 1'b0);
        `CHK(rdv[31:0], `PTB_SECONDARY_SPACE_BASE_RST)
        pci(`PTB_CMD_CFG_RD, 32'h18, 64'h0, 8'h0F, 1'b0);
        `CHK(rdv[31:0], 32'h0)
        pci(`PTB_CMD_CFG_WR, 32'h10, 64'h5A123456, 8'h0F, 1'b0);
        `CHK(fl[2:0], 3'b101)
        pci(`PTB_CMD_CFG_WR, 32'h14, 64'h0000C3FF, 8'h0F, 1'b0);
        pci(`PTB_CMD_CFG_RD, 32'h10, 64'h0, 8'h0F, 1'b0);
        `CHK(rdv[31:0], 32'h5A000000)
        pci(`PTB_CMD_CFG_RD, 32'h14, 64'h0, 8'h0F, 1'b0);
        `CHK(rdv[31:0], 32'h0000C301)
    endtask

    task automatic t_mem();
        int e0 = n_end;
        pci(`PTB_CMD_MEM_WR, 32'h5A000100, 64'hCAFEF00D, 8'h05, 1'b0);
        `CHK(fl, 6'b010001)
        `CHK(b_be, 8'h05)
        `CHK(b_wd[31:0], 32'hCAFEF00D)
        `CHK(b_wa, 24'h000100)
        `CHK(n_end - e0, 1)
        pci(`PTB_CMD_MEM_WR, 32'h5A000208, 64'h1122334455667788, 8'h96, 1'b1);
        `CHK(fl, 6'b110001)
        `CHK(b_be, 8'h96)
        `CHK(b_wd, 64'h1122334455667788)
        pci(`PTB_CMD_MEM_RD, 32'h5A000310, 64'h0, 8'hFF, 1'b1);
        `CHK(fl, 6'b110010)
        `CHK(rdv, {8'hC3, 24'h000310, 8'h3C, 24'h000310})
        pci(`PTB_CMD_IO_RD, 32'h0000C304, 64'h0, 8'h0F, 1'b0);
        `CHK(fl, 6'b001010)
        `CHK(trdy, 1'b1)
    endtask

    task automatic t_faults();
        logic [7:0] s0 = b_n;
        stall = 1'b1;
        pci(`PTB_CMD_MEM_RD, 32'h5A000400, 64'h0, 8'h0F, 1'b0);
        `CHK({stop, trdy, b_n - s0}, {2'b10, 8'h00})
        pci(`PTB_CMD_MEM_WR, 32'h5A000400, 64'h1, 8'h0F, 1'b0);
        `CHK({stop, trdy, b_n - s0}, {2'b10, 8'h00})
        stall = 1'b0;
        lat = 3'h2;
        pci(`PTB_CMD_MEM_WR, 32'h5A000500, 64'h0BADBEEF, 8'h0F, 1'b0);
        `CHK(b_n - s0, 8'h03)
        `CHK(b_wd[31:0], 32'h0BADBEEF)
        lat = 3'h0;
        err = 1'b1;
        pci(`PTB_CMD_MEM_WR, 32'h5A000600, 64'h2, 8'h0F, 1'b0);
        `CHK({stop, dev}, 2'b11)
        err = 1'b0;
        breq = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(grant, 1'b1)
        pci(`PTB_CMD_MEM_RD, 32'h5A000700, 64'h0, 8'h0F, 1'b0);
        `CHK({stop, dev, fl}, {2'b10, 6'h00})
        breq = 1'b0;
    endtask

    // Reset, then scenarios
    initial begin
        {frame_n, irdy_n, req64_n, idsel, stall, err, breq} = 7'b1110000;
        {ad, cbe_n, lat, fl, rst} = {64'h0, 8'hFF, 3'h0, 6'h00, 1'b1};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_cfg();
        t_mem();
        t_faults();
        results();
    end
endmodule
`default_nettype wire
